/* motor_fault_status_regs.sv */
/*
  Status register bank of a sensorless motor driver: sticky fault flags
  cleared by writing ones, plus rotor rate and rotor cycle time values.
  Assumes a serial register engine outside that presents a parallel
  read/write strobe port on clk, fault sources that are asynchronous
  levels, and rate and period values driven on clk by the commutation
  engine.
*/
// What this block does
// R1: Fault bit 15 sets on die over-temperature and bit 14 on heat warning.
// R2: Fault bit 13 sets when the main supply is above its upper limit.
// R3: Fault bit 12 sets when the switching regulator is overloaded.
// R4: Fault bit 11 sets on any motor-drive overcurrent event.
// R5: Fault bit 10 sets when the charge pump is undervoltage.
// R6: Bit 9 sets on regulator undervoltage, bit 8 on supply undervoltage.
// R7: Fault bit 7 sets when the 3.3 V linear regulator is undervoltage.
// R8: Software leaves reserved fault bit 6 alone; it always reads zero.
// R9: Bit 5 sets on a closed-loop stall and bit 4 on an open-loop stall.
// R10: Bit 3 sets with no motor found, bit 2 on an abnormal back-EMF constant.
// R11: Bit 1 sets on abnormal speed, bit 0 on a hardware current-limit trip.
// R12: All flags reset to zero, read back, and clear where a one is written.
// R13: Offset 0x01 reads the 16-bit rotor rate in tenths of hertz, reset zero.
// R14: Offset 0x02 reads the 16-bit rotor cycle time, reset zero.
// R15: Writing 0xFFFF clears every fault flag except those whose synchronised source is still active.
// R16: Flags stay set after their cause goes, and a new event beats a clear.
// R17: Writes to the read-only registers are ignored and reads change nothing.
`timescale 1ns/100ps
module motor_fault_status_regs
  import motor_fault_status_pkg::*;
(
  // Clock and reset.
  input  wire logic                  clk,
  input  wire logic                  reset,
  // Register access port from the serial engine.
  input  wire logic [ADDR_WIDTH-1:0] regAddr,
  input  wire logic                  regWrite,
  input  wire logic [DATA_WIDTH-1:0] regWriteData,
  input  wire logic                  regRead,
  output logic      [DATA_WIDTH-1:0] regReadData,
  output logic                       regReadValid,
  // Fault sources from protection circuits and lock detectors.
  input  wire logic                  dieHeatTrip,
  input  wire logic                  heatWarn,
  input  wire logic                  supplyOvervolt,
  input  wire logic                  buckOverload,
  input  wire logic                  phaseOverload,
  input  wire logic                  pumpUndervolt,
  input  wire logic                  buckUndervolt,
  input  wire logic                  supplyUndervolt,
  input  wire logic                  ldoUndervolt,
  input  wire logic                  closedLoopStall,
  input  wire logic                  openLoopStall,
  input  wire logic                  absentWinding,
  input  wire logic                  bemfConstAbnormal,
  input  wire logic                  rateAbnormal,
  input  wire logic                  hwLimitTrip,
  // Measurements from the commutation engine.
  input  wire logic [DATA_WIDTH-1:0] rotorRateIn,
  input  wire logic [DATA_WIDTH-1:0] rotorCycleTimeIn,
  // Fault flag view for the rest of the driver.
  output logic      [DATA_WIDTH-1:0] faultFlags
);

  logic [DATA_WIDTH-1:0] faultRaw;
  logic [DATA_WIDTH-1:0] faultSync;
  logic [DATA_WIDTH-1:0] clearMask;
  bank_state_t           state_q;
  bank_state_t           state_d;

  // The offsets and the fault map are laid out for these widths.
  if (ADDR_WIDTH != 8 || DATA_WIDTH != 16)
  begin : gWidthCheck
    $error("motor_fault_status_regs needs 8-bit offsets and 16-bit data.");
  end

  always_comb
  begin
    faultRaw                          = '0;
    faultRaw[DIE_HEAT_TRIP_BIT]       = dieHeatTrip;       // R1
    faultRaw[HEAT_WARN_BIT]           = heatWarn;          // R1
    faultRaw[SUPPLY_OVERVOLT_BIT]     = supplyOvervolt;    // R2
    faultRaw[BUCK_OVERLOAD_BIT]       = buckOverload;      // R3
    faultRaw[PHASE_OVERLOAD_BIT]      = phaseOverload;     // R4
    faultRaw[PUMP_UNDERVOLT_BIT]      = pumpUndervolt;     // R5
    faultRaw[BUCK_UNDERVOLT_BIT]      = buckUndervolt;     // R6
    faultRaw[SUPPLY_UNDERVOLT_BIT]    = supplyUndervolt;   // R6
    faultRaw[LDO_UNDERVOLT_BIT]       = ldoUndervolt;      // R7
    faultRaw[CLOSED_LOOP_STALL_BIT]   = closedLoopStall;   // R9
    faultRaw[OPEN_LOOP_STALL_BIT]     = openLoopStall;     // R9
    faultRaw[ABSENT_WINDING_BIT]      = absentWinding;     // R10
    faultRaw[BEMF_CONST_ABNORMAL_BIT] = bemfConstAbnormal; // R10
    faultRaw[RATE_ABNORMAL_BIT]       = rateAbnormal;      // R11
    faultRaw[HW_LIMIT_TRIP_BIT]       = hwLimitTrip;       // R11
  end

  // Fault sources are asynchronous levels; settle them first.
  level_sync #(
    .W (DATA_WIDTH)
  ) uFaultSync (
    .clk     (clk),
    .reset   (reset),
    .asyncIn (faultRaw),
    .syncOut (faultSync)
  );

  always_comb
  begin
    state_d   = state_q;
    clearMask = '0;

    // Ones written to the fault register clear those flags.
    if (regWrite && (regAddr == FAULT_FLAGS_OFFSET))
    begin
      clearMask = regWriteData; // R12 R15
    end

    // A live fault overrides a clear in the same cycle.
    state_d.faultFlags = ((state_q.faultFlags & ~clearMask) | faultSync)
                         & FAULT_IMPL_MASK; // R16 R8

    // Measurements follow the engine; host writes never reach them.
    state_d.rotorRate      = rotorRateIn;      // R13 R17
    state_d.rotorCycleTime = rotorCycleTimeIn; // R14 R17

    // Reads return one cycle later and disturb nothing.
    state_d.readValid = regRead; // R17
    if (regRead)
    begin
      case (regAddr)
        FAULT_FLAGS_OFFSET:      state_d.readData = state_q.faultFlags;
        ROTOR_RATE_OFFSET:       state_d.readData = state_q.rotorRate;
        ROTOR_CYCLE_TIME_OFFSET: state_d.readData = state_q.rotorCycleTime;
        default:                 state_d.readData = READ_DATA_RESET;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_q.faultFlags     <= FAULT_FLAGS_RESET; // R12
      state_q.rotorRate      <= ROTOR_RATE_RESET; // R13
      state_q.rotorCycleTime <= ROTOR_CYCLE_TIME_RESET; // R14
      state_q.readData       <= READ_DATA_RESET;
      state_q.readValid      <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign regReadData  = state_q.readData;
  assign regReadValid = state_q.readValid;
  assign faultFlags   = state_q.faultFlags;

endmodule : motor_fault_status_regs

/* motor_fault_status_pkg.sv */
/*
  Constants for the motor fault and status register bank: register
  offsets, fault bit positions, reset values and the state record.
  Assumes a 16-bit register data path and an 8-bit register address.
*/
package motor_fault_status_pkg;

  localparam int unsigned ADDR_WIDTH = 8;
  localparam int unsigned DATA_WIDTH = 16;

  // Register offsets.
  localparam logic [7:0] FAULT_FLAGS_OFFSET      = 8'h00;
  localparam logic [7:0] ROTOR_RATE_OFFSET       = 8'h01;
  localparam logic [7:0] ROTOR_CYCLE_TIME_OFFSET = 8'h02;

  // Reset values.
  localparam logic [15:0] FAULT_FLAGS_RESET      = 16'h0000;
  localparam logic [15:0] ROTOR_RATE_RESET       = 16'h0000;
  localparam logic [15:0] ROTOR_CYCLE_TIME_RESET = 16'h0000;
  localparam logic [15:0] READ_DATA_RESET        = 16'h0000;

  // Fault flag positions.
  localparam int unsigned DIE_HEAT_TRIP_BIT       = 15;
  localparam int unsigned HEAT_WARN_BIT           = 14;
  localparam int unsigned SUPPLY_OVERVOLT_BIT     = 13;
  localparam int unsigned BUCK_OVERLOAD_BIT       = 12;
  localparam int unsigned PHASE_OVERLOAD_BIT      = 11;
  localparam int unsigned PUMP_UNDERVOLT_BIT      = 10;
  localparam int unsigned BUCK_UNDERVOLT_BIT      = 9;
  localparam int unsigned SUPPLY_UNDERVOLT_BIT    = 8;
  localparam int unsigned LDO_UNDERVOLT_BIT       = 7;
  localparam int unsigned RESERVED_BIT            = 6;
  localparam int unsigned CLOSED_LOOP_STALL_BIT   = 5;
  localparam int unsigned OPEN_LOOP_STALL_BIT     = 4;
  localparam int unsigned ABSENT_WINDING_BIT      = 3;
  localparam int unsigned BEMF_CONST_ABNORMAL_BIT = 2;
  localparam int unsigned RATE_ABNORMAL_BIT       = 1;
  localparam int unsigned HW_LIMIT_TRIP_BIT       = 0;

  // Bits that hold a real flag; the reserved bit stays zero.
  localparam logic [15:0] FAULT_IMPL_MASK = 16'hFFBF;

  typedef struct packed {
    logic [15:0] faultFlags;
    logic [15:0] rotorRate;
    logic [15:0] rotorCycleTime;
    logic [15:0] readData;
    logic        readValid;
  } bank_state_t;

endpackage : motor_fault_status_pkg

/* level_sync.sv */
/*
  Two-flop synchroniser for a vector of independent level signals.
  Assumes each bit is a slow level from outside the clock domain.
*/
`timescale 1ns/100ps
module level_sync #(
  parameter int unsigned W = 16
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         reset,
  // Levels in and out.
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } sync_state_t;

  sync_state_t state_q;
  sync_state_t state_d;

  if (W < 1)
  begin : gWidthCheck
    $error("level_sync needs at least one bit.");
  end

  always_comb
  begin
    state_d        = state_q;
    state_d.stage1 = asyncIn;
    state_d.stage2 = state_q.stage1;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign syncOut = state_q.stage2;

endmodule : level_sync

/* motor_fault_status_regs_monitor.sv */
/* Port checker for the motor fault and status register bank.
   Assumes it is bound to motor_fault_status_regs by the line below. */
`timescale 1ns/100ps
module motor_fault_status_regs_monitor (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        reset,
  // Register access port.
  input wire logic [7:0]  regAddr,
  input wire logic        regWrite,
  input wire logic [15:0] regWriteData,
  input wire logic        regRead,
  input wire logic [15:0] regReadData,
  input wire logic        regReadValid,
  // Fault sources.
  input wire logic        dieHeatTrip,
  input wire logic        heatWarn,
  input wire logic        supplyOvervolt,
  input wire logic        buckOverload,
  input wire logic        phaseOverload,
  input wire logic        pumpUndervolt,
  input wire logic        buckUndervolt,
  input wire logic        supplyUndervolt,
  input wire logic        ldoUndervolt,
  input wire logic        closedLoopStall,
  input wire logic        openLoopStall,
  input wire logic        absentWinding,
  input wire logic        bemfConstAbnormal,
  input wire logic        rateAbnormal,
  input wire logic        hwLimitTrip,
  // Measurements and flag view.
  input wire logic [15:0] rotorRateIn,
  input wire logic [15:0] rotorCycleTimeIn,
  input wire logic [15:0] faultFlags
);
  logic [15:0] faultSrc;
  logic [1:0]  upCount_q;
  logic        faultWrite;

  assign faultWrite = regWrite && regAddr == 8'h00;
  assign faultSrc   = {dieHeatTrip, heatWarn, supplyOvervolt, buckOverload,
    phaseOverload, pumpUndervolt, buckUndervolt, supplyUndervolt, ldoUndervolt,
    1'b0, closedLoopStall, openLoopStall, absentWinding, bemfConstAbnormal,
    rateAbnormal, hwLimitTrip};

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      upCount_q <= 2'h0;
    end
    else if (upCount_q != 2'h3)
    begin
      upCount_q <= upCount_q + 2'h1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  sequence quiet3;
    (faultSrc == 16'h0000)[*3];
  endsequence

  a_flag_sets: assert property (
    upCount_q == 2'h3 |-> ($past(faultSrc, 3) & ~faultFlags) == 16'h0000)
    else $error("fault flag not set three cycles after its source");
  a_flag_sticky: assert property (
    !faultWrite |=> (faultFlags & $past(faultFlags)) == $past(faultFlags))
    else $error("fault flag lost without a clear");
  a_clear_ones: assert property (
    quiet3 ##0 faultWrite |=>
    faultFlags == ($past(faultFlags) & ~$past(regWriteData)))
    else $error("fault clear did not follow the written ones");
  a_read_faults: assert property (
    regRead && regAddr == 8'h00 |=> regReadData == $past(faultFlags))
    else $error("fault read wrong");
  a_read_rate: assert property (
    upCount_q != 2'h0 && regRead && regAddr == 8'h01 |=>
    regReadData == $past(rotorRateIn, 2))
    else $error("rate read wrong");
  a_read_cycle: assert property (
    upCount_q != 2'h0 && regRead && regAddr == 8'h02 |=>
    regReadData == $past(rotorCycleTimeIn, 2))
    else $error("cycle time read wrong");
  a_unmapped_zero: assert property (
    regRead && regAddr > 8'h02 |=> regReadData == 16'h0000)
    else $error("unmapped read not zero");
  a_valid_pulse: assert property (
    upCount_q != 2'h0 |-> regReadValid == $past(regRead))
    else $error("read valid wrong");
  a_data_holds: assert property (
    !regReadValid |-> $stable(regReadData))
    else $error("read data moved without a read");
  a_reserved_zero: assert property (
    faultFlags[6] == 1'b0)
    else $error("reserved fault bit set");
endmodule : motor_fault_status_regs_monitor
bind motor_fault_status_regs motor_fault_status_regs_monitor mon (.*);

/* reg_host.sv */
/* Host model that reads and writes the bank through its strobe port.
   Assumes one strobe pulse per access, driven 1 ns after the clk edge. */
`timescale 1ns/100ps
module reg_host (
  // Clock.
  input  wire logic        clk,
  // Register access port.
  input  wire logic [15:0] regReadData,
  output logic      [7:0]  regAddr,
  output logic             regWrite,
  output logic             regRead,
  output logic      [15:0] regWriteData
);
  initial {regAddr, regWrite, regRead, regWriteData} = '0;
  // Ones written clear flags; a byte of ones clears the low flags.
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [15:0] d, output logic [15:0] q);
    @(posedge clk);
    #1 {regWrite, regRead, regAddr, regWriteData} = {w, !w, a, d};
    @(posedge clk);
    #1 q = regReadData;
    {regWrite, regRead, regAddr, regWriteData} = {2'b00, ~a, ~d};
  endtask : xfer
endmodule : reg_host

/* tb.sv */
/* Self-checking bench for the fault and status bank.
   Assumes the host model drives the port and the checker is bound. */
`timescale 1ns/100ps
`define CHK(n, e, v) begin samplesChecked++; if ((v) !== (e)) begin \
  miscompares++; $display("MISMATCH %s exp %h got %h", n, e, v); end end
module tb;
  logic clk, reset, regWrite, regRead, regReadValid;
  logic [7:0] regAddr;
  logic [15:0] regWriteData, regReadData, faultFlags, src, rate, cyc, q;
  int miscompares, samplesChecked, cycles;
  motor_fault_status_regs dut (.clk(clk), .reset(reset), .regAddr(regAddr),
    .regWrite(regWrite), .regWriteData(regWriteData), .regRead(regRead),
    .regReadData(regReadData), .regReadValid(regReadValid),
    .dieHeatTrip(src[15]), .heatWarn(src[14]), .supplyOvervolt(src[13]),
    .buckOverload(src[12]), .phaseOverload(src[11]), .pumpUndervolt(src[10]),
    .buckUndervolt(src[9]), .supplyUndervolt(src[8]), .ldoUndervolt(src[7]),
    .closedLoopStall(src[5]), .openLoopStall(src[4]), .absentWinding(src[3]),
    .bemfConstAbnormal(src[2]), .rateAbnormal(src[1]), .hwLimitTrip(src[0]),
    .rotorRateIn(rate), .rotorCycleTimeIn(cyc), .faultFlags(faultFlags));
  reg_host host (.clk(clk), .regReadData(regReadData), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regWriteData(regWriteData));
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    host.xfer(1'b0, a, 16'h0000, q);
    `CHK("read", e, q)
    `CHK("read valid", 1'b1, regReadValid)
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    host.xfer(1'b1, a, d, q);
    `CHK("write valid", 1'b0, regReadValid)
  endtask : wr
  task automatic pulse(input int i);
    @(posedge clk);
    #1 src[i] = 1'b1;
    @(posedge clk);
    #1 src[i] = 1'b0;
    repeat (4) @(posedge clk);
  endtask : pulse
  task automatic t_each_flag;
    for (int i = 0; i < 16; i++)
    begin
      if (i != 6)
      begin
        pulse(i);
        wr(8'h01, 16'hFFFF);
        `CHK("flags", 16'h0001 << i, faultFlags)
        rd(8'h00, 16'h0001 << i);
        rd(8'h00, 16'h0001 << i);
        wr(8'h00, 16'h0001 << i);
        rd(8'h00, 16'h0000);
      end
    end
  endtask : t_each_flag
  task automatic t_set_wins;
    @(posedge clk);
    #1 src[15] = 1'b1;
    repeat (4) @(posedge clk);
    wr(8'h00, 16'hFFFF);
    rd(8'h00, 16'h8000);
    @(posedge clk);
    #1 src[15] = 1'b0;
    repeat (4) @(posedge clk);
    pulse(0);
    wr(8'h00, 16'h00FF);
    rd(8'h00, 16'h8000);
    wr(8'h00, 16'hFF00);
    rd(8'h00, 16'h0000);
  endtask : t_set_wins
  task automatic t_measure;
    {rate, cyc} = {16'h04D2, 16'hABCD};
    wr(8'h01, 16'h0000);
    wr(8'h02, 16'h0000);
    rd(8'h01, 16'h04D2);
    rd(8'h02, 16'hABCD);
    rd(8'h03, 16'h0000);
  endtask : t_measure
  task automatic t_reset;
    pulse(3);
    rd(8'h00, 16'h0008);
    @(posedge clk);
    #1 reset = 1'b1;
    @(posedge clk);
    `CHK("reset flags", 16'h0000, faultFlags)
    `CHK("reset data", 16'h0000, regReadData)
    `CHK("reset valid", 1'b0, regReadValid)
    @(posedge clk);
    #1 reset = 1'b0;
    rd(8'h00, 16'h0000);
  endtask : t_reset
  task automatic giveVerdict;
    $display("checked %0d mismatches %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : giveVerdict
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      giveVerdict;
    end
  end
  initial
  begin
    {reset, src, rate, cyc} = {1'b1, 48'h0};
    repeat (4) @(posedge clk);
    #1 reset = 1'b0;
    for (int a = 0; a < 3; a++) rd(8'(a), 16'h0000);
    t_each_flag;
    t_set_wins;
    t_measure;
    t_reset;
    giveVerdict;
  end
endmodule : tb
